// [src/sas_pkg.sv]
/*
 * Package of the successive-approximation converter sequencer: register map,
 * field positions, reset values, phase timing, state types and carriers.
 * Assumes a 32-bit APB master and an analog macro clocked on the same clock.
 */
package sas_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] IDX_RESULT = 10'h070;
    localparam logic [9:0] IDX_CONTROL_STATUS = 10'h071;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h072;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h073;
    localparam logic [9:0] IDX_PIN_LEVEL = 10'h074;
    localparam int ADDR_W = 12;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int CS_CHAN_LSB = 0;
    localparam int CS_CHAN_W = 4;
    localparam int CS_ON_BIT = 5;
    localparam int CS_DONE_BIT = 7;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_W = 1;
    localparam int CODE_W = 8;
    localparam int PIN_W = 16;
    localparam logic [CODE_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MSB = 8'h80;
    localparam logic [CS_CHAN_W-1:0] CHAN_RESET = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ************************************************************
    // Conversion timing
    // ************************************************************
    localparam int TOTAL_ADC_CLKS = 12;
    localparam int SAR_STEPS = 8;
    localparam int LOAD_ADC_CLKS = TOTAL_ADC_CLKS - SAR_STEPS;
    localparam int CPU_PER_ADC_DEFAULT = 2;
    localparam int CNT_W = 5;
    localparam int STEP_W = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_LOAD,
        PH_CONV
    } sas_phase_e;

    // Drive toward the analog multiplexer and sample-and-hold
    typedef struct packed {
        logic power;
        logic sample;
        logic [CS_CHAN_W-1:0] chan;
        logic [CODE_W-1:0] code;
    } sas_ana_s;

    // Whole state of the sequencer
    typedef struct packed {
        sas_phase_e phase;
        logic conv_on;
        logic [CS_CHAN_W-1:0] chan;
        logic done;
        logic [CODE_W-1:0] result;
        logic [CODE_W-1:0] acc;
        logic [STEP_W-1:0] bitpos;
        logic [CNT_W-1:0] cnt;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        sas_ana_s ana;
    } sas_state_s;

endpackage : sas_pkg

// [src/sas_adc_sequencer.sv]
/*
 * Control, sequencing and result logic of an 8-bit successive-approximation
 * converter with up to sixteen multiplexed inputs, reached over APB.
 * Assumes the comparator output of the analog macro is registered on clk_in
 * (same clock, no synchroniser), and that the port pins arrive asynchronously.
 *
 * Also assumes:
 * - an APB master that never issues two setups without an access
 * - deep stop requests come from logic on the same clock
 * - the comparator answers one cycle after a code change
 * - software leaves analog pins as plain inputs
 */

// Contract
// - Input at or above high reference gives result FFh, no overflow flag.
// - Input at or below low reference gives result 00h.
// - Conversion is a sample-load phase, then eight steps with capacitor disconnected.
// - While switched on, load and convert phases repeat without software action.
// - One conversion takes twelve converter clocks; converter clock is half CPU clock.
// - Analog use of a pin still lets the port read it as logic.
// - Low nibble of control/status picks input 0 to 15, plain binary.
// - Setting converter_on powers up, starts, then converts the channel continuously.
// - End of conversion sets conversion_done_flag, bit 7, no interrupt from it; code also sets irq_status, raising irq_out when irq_mask enables it.
// - Result stays unchanged until the next conversion finishes, then replaced.
// - Control/status write with converter_on aborts, clears done flag, restarts.
// - Done flag clears on result read or control/status write.
// - Clearing converter_on switches converter off and stops conversions.
// - Idle wait low-power mode leaves converter operation unaffected.
// - Deep stop disables converter; software waits for stabilisation after wakeup.
// - Result register is read-only, unsigned 00h to FFh, resets to zero.
module sas_adc_sequencer
    import sas_pkg::*;
#(
    parameter int CPU_PER_ADC = CPU_PER_ADC_DEFAULT,
    parameter int NUM_CH = 16
) (
    input wire logic clk_in,                   // CPU clock, 50 MHz
    input wire logic reset_in,                 // Synchronous reset, active high
    input wire logic psel_in,                  // APB select
    input wire logic penable_in,               // APB access phase
    input wire logic pwrite_in,                // APB direction, high for write
    input wire logic [ADDR_W-1:0] paddr_in,    // APB byte address
    input wire logic [31:0] pwdata_in,         // APB write data
    output logic [31:0] prdata_out,            // APB read data
    output logic pready_out,                   // APB ready
    output logic pslverr_out,                  // APB error on unmapped address
    input wire logic cmp_in,                   // Comparator: input at or above DAC code
    input wire logic halt_in,                  // Deep stop request from power control
    input wire logic [PIN_W-1:0] pin_in,       // Raw port pin levels
    output sas_ana_s ana_out,                  // Power, sample, channel and DAC code
    output logic irq_out                       // Level interrupt, masked done events
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    localparam int LOAD_CYC = LOAD_ADC_CLKS * CPU_PER_ADC;

    // Divider below two leaves no judge cycle in a step
    // Load length must fit the phase counter
    // Channel count must fit the select field

    // A step needs one cycle to present the code and one to judge it
    if (CPU_PER_ADC < 2 || LOAD_CYC > (1 << CNT_W)) begin : g_bad_div
        $error("sas_adc_sequencer: CPU_PER_ADC out of range");
    end
    if (NUM_CH < 1 || NUM_CH > (1 << CS_CHAN_W)) begin : g_bad_ch
        $error("sas_adc_sequencer: NUM_CH out of range");
    end

    localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_CYC - 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(CPU_PER_ADC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [STEP_W-1:0] STEP_FIRST = STEP_W'(SAR_STEPS - 1);
    localparam logic [STEP_W-1:0] STEP_END = STEP_W'(0);

    // ************************************************************
    // State
    // ************************************************************
    sas_state_s state_r;
    sas_state_s state_nxt;

    // ************************************************************
    // Register map
    // ************************************************************
    // Result: code of last conversion, read only
    // Control/status: channel, on bit, done bit
    // Control/status: reserved bits read zero
    // Interrupt status: done event, write one to clear
    // Interrupt mask: enables the done event
    // Pin level: synchronised pins, read only
    // Bad address: error response, no effect
    // Read-only writes: no error, no effect
    // Upper read data bits: zero

    // Bus timing
    // - Setup captured at one edge
    // - Answer stands one cycle after it
    // - Write lands at the end of access
    // - No wait states
    // - Next setup may follow at once

    // Bus decode helpers
    logic setup_cyc;
    logic wr_acc;
    logic rd_acc;
    logic [9:0] idx;
    logic aligned;
    logic [31:0] csr_view;
    logic [31:0] pin_view;

    // Single-bit weight of the current approximation step
    function automatic logic [CODE_W-1:0] step_bit(input logic [STEP_W-1:0] pos);
        step_bit = CODE_W'(1) << pos;
    endfunction

    // ************************************************************
    // APB decode
    // ************************************************************
    // A transfer takes effect at the edge where the access phase meets ready
    assign setup_cyc = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && state_r.pready && pwrite_in;
    assign rd_acc = psel_in && penable_in && state_r.pready && !pwrite_in;
    assign idx = paddr_in[ADDR_W-1:2];
    assign aligned = (paddr_in[1:0] == 2'b00);

    // Control/status as software reads it, reserved bits zero
    always_comb begin
        csr_view = RDATA_ZERO;
        csr_view[CS_CHAN_LSB +: CS_CHAN_W] = state_r.chan;
        csr_view[CS_ON_BIT] = state_r.conv_on;
        csr_view[CS_DONE_BIT] = state_r.done;
    end

    // Digital view of the pins, independent of converter use
    always_comb begin
        pin_view = RDATA_ZERO;
        pin_view[PIN_W-1:0] = state_r.pin_s2;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;

        // Two-flop synchroniser for the port pins
        state_nxt.pin_s1 = pin_in;
        state_nxt.pin_s2 = state_r.pin_s1;

        // Bus answer: one setup cycle, ready in the access cycle
        state_nxt.pready = setup_cyc;
        state_nxt.pslverr = 1'b0;
        state_nxt.prdata = RDATA_ZERO;
        if (setup_cyc) begin
            if (!aligned) begin
                state_nxt.pslverr = 1'b1;
            end else begin
                unique case (idx)
                    IDX_RESULT: state_nxt.prdata = {24'h00_0000, state_r.result};
                    IDX_CONTROL_STATUS: state_nxt.prdata = csr_view;
                    IDX_IRQ_STATUS: state_nxt.prdata = {31'h0000_0000, state_r.irq_status};
                    IDX_IRQ_MASK: state_nxt.prdata = {31'h0000_0000, state_r.irq_mask};
                    IDX_PIN_LEVEL: state_nxt.prdata = pin_view;
                    default: state_nxt.pslverr = 1'b1;
                endcase
            end
        end

        // Reading the result clears the done flag
        if (rd_acc && aligned && idx == IDX_RESULT) begin
            state_nxt.done = 1'b0;
        end

        // Phase timing, default divider
        // - Load: eight cycles on the input
        // - Convert: eight steps of two cycles
        // - Cycle 0 of a step shows the code
        // - Cycle 1 judges the comparator
        // - Result lands after the last step
        // - Twenty-four cycles, then load again
        // Hazard: comparator has one cycle
        // Hazard: deep stop loses the work

        // Conversion sequencer: load phase, then eight approximation steps
        unique case (state_r.phase)
            PH_IDLE: begin
                state_nxt.cnt = CNT_ZERO;
                if (state_r.conv_on && !halt_in) begin
                    state_nxt.phase = PH_LOAD;
                end
            end
            PH_LOAD: begin
                // Capacitor follows the selected input
                if (state_r.cnt == LOAD_LAST) begin
                    state_nxt.phase = PH_CONV;
                    state_nxt.cnt = CNT_ZERO;
                    state_nxt.bitpos = STEP_FIRST;
                    state_nxt.acc = CODE_ZERO;
                end else begin
                    state_nxt.cnt = state_r.cnt + CNT_W'(1);
                end
            end
            PH_CONV: begin
                if (state_r.cnt == STEP_LAST) begin
                    state_nxt.cnt = CNT_ZERO;
                    // Keep the trial bit only when input is at or above the code
                    if (cmp_in) begin
                        state_nxt.acc = state_r.ana.code;
                    end else begin
                        state_nxt.acc = state_r.acc;
                    end
                    if (state_r.bitpos == STEP_END) begin
                        // Result and flag land together, then the next sample starts
                        state_nxt.result = state_nxt.acc;
                        state_nxt.done = 1'b1;
                        state_nxt.irq_status[IRQ_DONE_BIT] = 1'b1;
                        state_nxt.phase = PH_LOAD;
                    end else begin
                        state_nxt.bitpos = state_r.bitpos - STEP_W'(1);
                    end
                end else begin
                    state_nxt.cnt = state_r.cnt + CNT_W'(1);
                end
            end
        endcase

        // Deep stop shuts the converter down; idle wait has no input here
        if (halt_in) begin
            state_nxt.phase = PH_IDLE;
            state_nxt.cnt = CNT_ZERO;
        end

        // Control/status write: new channel and enable, abort and restart
        if (wr_acc && aligned && idx == IDX_CONTROL_STATUS) begin
            state_nxt.chan = pwdata_in[CS_CHAN_LSB +: CS_CHAN_W];
            state_nxt.conv_on = pwdata_in[CS_ON_BIT];
            state_nxt.done = 1'b0;
            state_nxt.result = state_r.result;
            state_nxt.cnt = CNT_ZERO;
            state_nxt.acc = CODE_ZERO;
            if (pwdata_in[CS_ON_BIT] && !halt_in) begin
                state_nxt.phase = PH_LOAD;
            end else begin
                state_nxt.phase = PH_IDLE;
            end
        end

        // Interrupt status, write one to clear; a same-cycle event wins unless halt_in is also high
        if (wr_acc && aligned && idx == IDX_IRQ_STATUS) begin
            state_nxt.irq_status = state_r.irq_status & ~pwdata_in[IRQ_W-1:0];
            if (state_r.phase == PH_CONV && state_nxt.phase == PH_LOAD && state_nxt.done) begin
                state_nxt.irq_status[IRQ_DONE_BIT] = 1'b1;
            end
        end
        if (wr_acc && aligned && idx == IDX_IRQ_MASK) begin
            state_nxt.irq_mask = pwdata_in[IRQ_W-1:0];
        end
        state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);

        // Drive toward the analog macro
        state_nxt.ana.power = state_nxt.conv_on && !halt_in;
        state_nxt.ana.sample = (state_nxt.phase == PH_LOAD);
        state_nxt.ana.chan = state_nxt.chan;
        if (state_nxt.phase == PH_CONV) begin
            state_nxt.ana.code = state_nxt.acc | step_bit(state_nxt.bitpos);
        end else begin
            state_nxt.ana.code = CODE_ZERO;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            // Sequencer idle, converter off

            state_r.phase <= PH_IDLE;
            state_r.conv_on <= 1'b0;
            state_r.chan <= CHAN_RESET;

            // Flag and result cleared

            state_r.done <= 1'b0;
            state_r.result <= RESULT_RESET;

            // Approximation working state

            state_r.acc <= CODE_ZERO;
            state_r.bitpos <= STEP_FIRST;
            state_r.cnt <= CNT_ZERO;

            // Interrupt state

            state_r.irq_status <= IRQ_RESET;
            state_r.irq_mask <= IRQ_RESET;
            state_r.irq <= 1'b0;

            // Bus answer

            state_r.prdata <= RDATA_ZERO;
            state_r.pready <= 1'b0;
            state_r.pslverr <= 1'b0;

            // Pin synchroniser

            state_r.pin_s1 <= '0;
            state_r.pin_s2 <= '0;

            // Analog drive off

            state_r.ana <= '0;

        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Outputs, all straight from the state register
    // ************************************************************

    // Bus answer

    assign prdata_out = state_r.prdata;
    assign pready_out = state_r.pready;
    assign pslverr_out = state_r.pslverr;

    // Analog drive

    assign ana_out = state_r.ana;

    // Interrupt level

    assign irq_out = state_r.irq;


endmodule // sas_adc_sequencer

// [tb/sas_adc_checker.sv]
/* Port-level checker of the converter sequencer: APB timing, phase lengths.
   Assumes it is bound to the top module and sees only its ports. */
module sas_adc_checker
    import sas_pkg::*;
#(
    parameter int CPU_PER_ADC = CPU_PER_ADC_DEFAULT
) (
    input wire logic clk_in,        // CPU clock
    input wire logic reset_in,      // Synchronous reset
    input wire logic psel_in,       // APB select
    input wire logic penable_in,    // APB access phase
    input wire logic pwrite_in,     // APB direction
    input wire logic halt_in,       // Deep stop
    input wire logic [31:0] prdata_out, // Read data
    input wire logic pready_out,    // Ready
    input wire logic pslverr_out,   // Error
    input wire sas_ana_s ana_out    // Analog drive
);
    localparam int LOAD_CYC = LOAD_ADC_CLKS * CPU_PER_ADC;
    localparam int CONV_CYC = SAR_STEPS * CPU_PER_ADC;
    logic prev_r, quiet_r, quiet_nxt, chg;
    logic [15:0] run_r, run_nxt;
    // Length of the current sample level; quiet means no write, halt or power-off
    always_comb begin
        chg = ana_out.sample != prev_r;
        run_nxt = chg ? 16'h0001 : run_r + 16'h0001;
        quiet_nxt = chg ? 1'b1 : quiet_r;
        if ((psel_in && penable_in && pwrite_in) || halt_in || !ana_out.power) quiet_nxt = 1'b0;
    end
    // Register the helper state
    always_ff @(posedge clk_in) begin
        prev_r <= reset_in ? 1'b0 : ana_out.sample;
        run_r <= reset_in ? 16'h0000 : run_nxt;
        quiet_r <= reset_in ? 1'b0 : quiet_nxt;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_load_end;
        $fell(ana_out.sample) && quiet_r;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready_out) else $error("ready missing after setup");
    a_ready_single: assert property (pready_out |=> !pready_out) else $error("ready held too long");
    a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == RDATA_ZERO) else $error("read data not zero");
    a_load_length: assert property (s_load_end |-> run_r == LOAD_CYC) else $error("load phase length");
    a_msb_trial: assert property (s_load_end |-> ana_out.code == CODE_MSB) else $error("first trial not msb");
    a_conv_length: assert property ($rose(ana_out.sample) && quiet_r |-> run_r == CONV_CYC)
        else $error("conversion phase length");
    a_halt_unpowers: assert property (halt_in |=> !ana_out.power) else $error("powered in deep stop");
    a_load_code_zero: assert property (ana_out.sample |-> ana_out.code == CODE_ZERO) else $error("code while sampling");
endmodule // sas_adc_checker

bind sas_adc_sequencer sas_adc_checker #(.CPU_PER_ADC(CPU_PER_ADC)) chk_u (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .halt_in(halt_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .ana_out(ana_out));

// [tb/sas_analog_model.sv]
/* Model of the input multiplexer, sample capacitor and comparator.
   Assumes the sequencer drives it on the same clock. */
module sas_analog_model
    import sas_pkg::*;
(
    input wire logic clk_in,                 // CPU clock
    input wire sas_ana_s ana_in,             // Drive from the sequencer
    input wire logic [15:0][7:0] level_in,   // Input level per channel
    output logic cmp_out                     // Held level at or above code
);
    // Pins act as plain inputs here: no pull-up, no interrupt
    logic [7:0] held_r;
    // Capacitor follows the selected input only while sampling, compare is registered
    always_ff @(posedge clk_in) begin
        if (ana_in.sample) held_r <= level_in[ana_in.chan];
        cmp_out <= ana_in.power & (ana_in.code <= held_r);
    end
endmodule // sas_analog_model

// [tb/tb_top.sv]
/* Self-checking bench of the converter sequencer over APB.
   Assumes the analog model on the far side and the bound checker. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sas_pkg::*;
    localparam logic [ADDR_W-1:0] A_RES = {IDX_RESULT, 2'b00};
    localparam logic [ADDR_W-1:0] A_CS = {IDX_CONTROL_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] A_IRQS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] A_PIN = {IDX_PIN_LEVEL, 2'b00};
    logic clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, cmp_in, halt_in, irq_out;
    logic last_err;
    logic [ADDR_W-1:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic [PIN_W-1:0] pin_in;
    logic [15:0][7:0] level_r;
    sas_ana_s ana_out;
    int n_fail, num_checks;
    sas_adc_sequencer dut_u (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .cmp_in(cmp_in), .halt_in(halt_in),
        .pin_in(pin_in), .ana_out(ana_out), .irq_out(irq_out));
    sas_analog_model ana_u (.clk_in(clk_in), .ana_in(ana_out), .level_in(level_r), .cmp_out(cmp_in));
    // Compare and count
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until ready is seen
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] v);
        @(posedge clk_in);
        psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        v = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'b0; penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] v;
        apb(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        apb(1'b0, a, 32'h0000_0000, v);
    endtask
    // Poll the done flag for a bounded number of reads
    task automatic wait_done();
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < 30 && !v[CS_DONE_BIT]; i++) rd(A_CS, v);
        check("done_flag", 32'h0000_0001, {31'h0, v[CS_DONE_BIT]});
    endtask
    task automatic t_regs();
        logic [31:0] v;
        rd(A_RES, v); check("result_reset", 32'h0000_0000, v);
        rd(A_CS, v); check("csr_reset", 32'h0000_0000, v);
        wr(A_RES, 32'h0000_00AB); rd(A_RES, v); check("result_ro", 32'h0000_0000, v);
        wr(A_CS, 32'h0000_005A); rd(A_CS, v); check("csr_reserved", 32'h0000_000A, v);
        rd(12'h1D4, v); check("unmapped_err", 32'h0000_0001, {31'h0, last_err});
        pin_in <= 16'hA5C3;
        repeat (3) @(posedge clk_in);
        rd(A_PIN, v); check("pin_level", 32'h0000_A5C3, v);
    endtask
    task automatic t_channels();
        logic [31:0] v;
        for (int c = 0; c < 16; c++) begin
            wr(A_CS, 32'h0000_0020 | c); wait_done();
            check("chan", c, {28'h0, ana_out.chan});
            check("no_irq", 32'h0000_0000, {31'h0, irq_out});
            rd(A_RES, v); check("result", {24'h0, level_r[c]}, v);
            rd(A_CS, v); check("done_clr_read", 32'h0000_0000, {31'h0, v[CS_DONE_BIT]});
        end
    endtask
    task automatic t_continuous();
        logic [31:0] v;
        wr(A_CS, 32'h0000_0023); wait_done();
        level_r[3] <= 8'h5C;
        rd(A_RES, v); check("result_kept", 32'h0000_0033, v);
        wait_done(); rd(A_RES, v); wait_done(); rd(A_RES, v);
        check("result_new", 32'h0000_005C, v);
    endtask
    task automatic t_abort_irq();
        logic [31:0] v;
        wr(A_MASK, 32'h0000_0001); wr(A_CS, 32'h0000_0025); wait_done();
        check("irq_set", 32'h0000_0001, {31'h0, irq_out});
        wr(A_CS, 32'h0000_0025); rd(A_CS, v); check("done_abort", 32'h0000_0025, v);
        wr(A_IRQS, 32'h0000_0001); repeat (2) @(posedge clk_in);
        check("irq_clear", 32'h0000_0000, {31'h0, irq_out});
        wr(A_MASK, 32'h0000_0000);
    endtask
    task automatic t_halt_off();
        logic [31:0] v;
        rd(A_RES, v); halt_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("halt_power", 32'h0000_0000, {31'h0, ana_out.power});
        halt_in <= 1'b0; wait_done();
        wr(A_CS, 32'h0000_0005); repeat (40) @(posedge clk_in);
        rd(A_CS, v); check("off_no_done", 32'h0000_0005, v);
        check("off_power", 32'h0000_0000, {31'h0, ana_out.power});
    endtask
    // Verdict and end of run
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Clock at 50 MHz
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        reset_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = '0;
        pwdata_in = '0; halt_in = 1'b0; pin_in = '0; n_fail = 0; num_checks = 0;
        for (int i = 0; i < 16; i++) level_r[i] = 8'(i * 17);
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs(); t_channels(); t_continuous(); t_abort_irq(); t_halt_off();
        stop_test();
    end
endmodule // tb_top
